// ===== hw/scd_stop_collide.sv
`timescale 1ns/1ns
`default_nettype none
module scd_stop_collide
   import scd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   output logic             irq_o
);
   logic [1:0]          pins_s;
   logic                scl_s;
   logic                sda_s;
   scd_state_type       state_ff,     nxt_state;
   logic [RELOAD_W-1:0] brg_ff,       nxt_brg;
   logic [7:0]          buf_ff,       nxt_buf;
   logic [7:0]          reload_ff,    nxt_reload;
   logic [7:0]          mask_reg_ff,  nxt_mask_reg;
   logic [7:0]          ctrl1_ff,     nxt_ctrl1;
   logic [5:0]          seq_ff,       nxt_seq;
   logic [4:0]          adm_ff,       nxt_adm;
   logic                gcen_ff,      nxt_gcen;
   logic                stop_det_ff,  nxt_stop_det;
   logic [IRQ_W-1:0]    irq_stat_ff,  nxt_irq_stat;
   logic [IRQ_W-1:0]    irq_mask_ff,  nxt_irq_mask;
   logic                scl_rel_ff,   nxt_scl_rel;
   logic                sda_rel_ff,   nxt_sda_rel;
   logic [1:0]          settle_ff,    nxt_settle;
   logic                ack_ff,       nxt_ack;
   logic [31:0]         dat_ff,       nxt_dat;
   logic                wr;
   logic                en;
   logic                master;
   logic                coll;
   logic                done;

   // Counter reload value taken from the low bits of the reload register.
   function automatic logic [RELOAD_W-1:0] brg_load(input logic [7:0] r);
      return r[RELOAD_W-1:0];
   endfunction : brg_load

   // Both bus lines arrive from outside and are synchronised first.
   scd_sync2 #(.W(2)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({scl_i, sda_i}),
      .q_o   (pins_s)
   );

   // Decoded handles shared by the next-state logic.
   assign scl_s  = pins_s[1];
   assign sda_s  = pins_s[0];
   assign wr     = cyc_i & stb_i & we_i & ack_ff & sel_i[0];
   assign en     = ctrl1_ff[C1_EN];
   assign master = (ctrl1_ff[3:0] == MODE_MASTER);

   // Next values for the bus slave, registers and stop sequencer.
   always_comb begin
      nxt_state    = state_ff;
      nxt_brg      = brg_ff;
      nxt_buf      = buf_ff;
      nxt_reload   = reload_ff;
      nxt_mask_reg = mask_reg_ff;
      nxt_ctrl1    = ctrl1_ff;
      nxt_seq      = seq_ff;
      nxt_adm      = adm_ff;
      nxt_gcen     = gcen_ff;
      nxt_stop_det = stop_det_ff;
      nxt_irq_stat = irq_stat_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_scl_rel  = scl_rel_ff;
      nxt_sda_rel  = sda_rel_ff;
      nxt_ack      = cyc_i & stb_i & ~ack_ff;
      nxt_dat      = dat_ff;
      nxt_settle   = settle_ff;
      coll         = 1'b0;
      done         = 1'b0;
      if (brg_ff != '0) begin
         nxt_brg = brg_ff - 1'b1;
      end
      if (settle_ff != '0) begin
         nxt_settle = settle_ff - 1'b1;
      end
      // Read data is captured on the same edge that raises the acknowledge.
      if (cyc_i && stb_i && !ack_ff) begin
         case (adr_i)
            ADR_BUF:      nxt_dat = {24'h0, buf_ff};
            ADR_RELOAD:   nxt_dat = {24'h0, (ctrl1_ff[3:0] == MODE_SLV_MASK) ? mask_reg_ff : reload_ff};
            ADR_CTRL1:    nxt_dat = {24'h0, ctrl1_ff};
            ADR_CTRL2:    nxt_dat = {24'h0, gcen_ff, 1'b0, master ? seq_ff : {adm_ff, seq_ff[C2_SEN]}};
            ADR_STAT:     nxt_dat = {27'h0, stop_det_ff, 4'h0};
            ADR_IRQ_STAT: nxt_dat = {30'h0, irq_stat_ff};
            ADR_IRQ_MASK: nxt_dat = {30'h0, irq_mask_ff};
            default:      nxt_dat = 32'h0;
         endcase
      end
      // Writes land on the edge after the acknowledge rises, the one that drops it.
      if (wr) begin
         case (adr_i)
            ADR_BUF: begin
               if (state_ff != SCD_IDLE) begin
                  nxt_ctrl1[C1_WCOL] = 1'b1;
               end else begin
                  nxt_buf = dat_i[7:0];
               end
            end
            ADR_RELOAD: begin
               if (ctrl1_ff[3:0] == MODE_SLV_MASK) begin
                  nxt_mask_reg = dat_i[7:0];
               end else begin
                  nxt_reload = dat_i[7:0];
               end
            end
            ADR_CTRL1:    nxt_ctrl1 = dat_i[7:0];
            ADR_CTRL2: begin
               nxt_gcen         = dat_i[C2_GCEN];
               nxt_seq[C2_SEN]  = dat_i[C2_SEN];
               if (!master) begin
                  nxt_adm = dat_i[5:1];
               end else begin
                  nxt_seq[5:1] = dat_i[5:1];
                  if (irq_stat_ff[IRQ_COLL] || state_ff != SCD_IDLE) begin
                     nxt_seq[C2_PEN] = seq_ff[C2_PEN];
                  end
               end
            end
            ADR_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~dat_i[IRQ_W-1:0];
            ADR_IRQ_MASK: nxt_irq_mask = dat_i[IRQ_W-1:0];
            default: ;
         endcase
      end
      // Stop sequencer.
      case (state_ff)
         SCD_IDLE: begin
            nxt_scl_rel = 1'b1;
            nxt_sda_rel = 1'b1;
            if (en && master && seq_ff[C2_PEN] && !irq_stat_ff[IRQ_COLL]) begin
               nxt_scl_rel  = 1'b0;
               nxt_sda_rel  = 1'b0;
               nxt_stop_det = 1'b0;
               nxt_state    = SCD_SDA_LOW;
            end
         end
         SCD_SDA_LOW: begin
            if (!sda_s) begin
               nxt_scl_rel = 1'b1;
               nxt_state   = SCD_SCL_WAIT;
            end
         end
         SCD_SCL_WAIT: begin
            if (scl_s) begin
               nxt_brg   = brg_load(reload_ff);
               nxt_state = SCD_HOLD;
            end
         end
         SCD_HOLD: begin
            if (!scl_s) begin
               coll = 1'b1;
            end else if (brg_ff == '0) begin
               nxt_sda_rel = 1'b1;
               nxt_brg     = brg_load(reload_ff);
               nxt_settle  = SETTLE_CYC;
               nxt_state   = SCD_SDA_REL;
            end
         end
         SCD_SDA_REL: begin
            if (!scl_s && !sda_s) begin
               coll = 1'b1;
            end else if (brg_ff == '0 && settle_ff == '0) begin
               // Short reloads would otherwise see the stale low of our own release.
               if (!sda_s) begin
                  coll = 1'b1;
               end else if (scl_s) begin
                  nxt_stop_det = 1'b1;
                  nxt_brg      = brg_load(reload_ff);
                  nxt_state    = SCD_TAIL;
               end
            end
         end
         SCD_TAIL: begin
            if (brg_ff == '0) begin
               done      = 1'b1;
               nxt_state = SCD_IDLE;
            end
         end
         default: nxt_state = SCD_IDLE;
      endcase
      // Collision abort; hardware set wins over a software clear.
      if (coll) begin
         nxt_state              = SCD_IDLE;
         nxt_scl_rel            = 1'b1;
         nxt_sda_rel            = 1'b1;
         nxt_seq                = 6'h0;
         nxt_irq_stat[IRQ_COLL] = 1'b1;
      end
      if (done) begin
         nxt_seq[C2_PEN]        = 1'b0;
         nxt_irq_stat[IRQ_XFER] = 1'b1;
      end
      // A disabled port is held idle with both lines released.
      if (!en) begin
         nxt_state    = SCD_IDLE;
         nxt_scl_rel  = 1'b1;
         nxt_sda_rel  = 1'b1;
         nxt_stop_det = 1'b0;
      end
   end

   // State registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff    <= SCD_IDLE;
         brg_ff      <= '0;
         buf_ff      <= RST_BYTE;
         reload_ff   <= RST_BYTE;
         mask_reg_ff <= RST_MASK;
         ctrl1_ff    <= RST_BYTE;
         seq_ff      <= 6'h0;
         adm_ff      <= 5'h0;
         gcen_ff     <= 1'b0;
         stop_det_ff <= 1'b0;
         irq_stat_ff <= RST_IRQ;
         irq_mask_ff <= RST_IRQ;
         scl_rel_ff  <= 1'b1;
         sda_rel_ff  <= 1'b1;
         ack_ff      <= 1'b0;
         dat_ff      <= 32'h0;
         settle_ff   <= 2'h0;
      end else begin
         state_ff    <= nxt_state;
         brg_ff      <= nxt_brg;
         buf_ff      <= nxt_buf;
         reload_ff   <= nxt_reload;
         mask_reg_ff <= nxt_mask_reg;
         ctrl1_ff    <= nxt_ctrl1;
         seq_ff      <= nxt_seq;
         adm_ff      <= nxt_adm;
         gcen_ff     <= nxt_gcen;
         stop_det_ff <= nxt_stop_det;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         scl_rel_ff  <= nxt_scl_rel;
         sda_rel_ff  <= nxt_sda_rel;
         ack_ff      <= nxt_ack;
         dat_ff      <= nxt_dat;
         settle_ff   <= nxt_settle;
      end
   end

   // Open-drain outputs only ever pull low; enables are low while driving.
   assign scl_o      = 1'b0;
   assign sda_o      = 1'b0;
   assign scl_oe_n_o = scl_rel_ff;
   assign sda_oe_n_o = sda_rel_ff;
   assign ack_o      = ack_ff;
   assign dat_o      = dat_ff;
   assign irq_o      = |(irq_stat_ff & irq_mask_ff);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_tail_expire;
      state_ff == SCD_TAIL && brg_ff == '0 && en;
   endsequence

   sequence s_stop_finished;
      !seq_ff[C2_PEN] && irq_stat_ff[IRQ_XFER] && state_ff == SCD_IDLE;
   endsequence

   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acknowledged after one cycle");
   a_sda_first: assert property (state_ff == SCD_SDA_LOW |-> !sda_oe_n_o && !scl_oe_n_o)
      else $error("stop did not start with data driven low");
   a_scl_release: assert property (state_ff == SCD_SDA_LOW && !sda_s && en |=> scl_oe_n_o)
      else $error("clock not released after data seen low");
   a_brg_load: assert property (state_ff == SCD_SCL_WAIT && scl_s && en |=> brg_ff == brg_load(reload_ff))
      else $error("counter not loaded from reload bits");
   a_late_sda_coll: assert property (state_ff == SCD_SDA_REL && brg_ff == '0 && !sda_s && en && settle_ff == '0
      |=> irq_stat_ff[IRQ_COLL] && state_ff == SCD_IDLE)
      else $error("low data at expiry not flagged");
   a_scl_low_coll: assert property (state_ff == SCD_HOLD && !scl_s && en |=> irq_stat_ff[IRQ_COLL])
      else $error("early clock low not flagged");
   a_abort_release: assert property ($rose(irq_stat_ff[IRQ_COLL]) |-> sda_oe_n_o && scl_oe_n_o && seq_ff == 6'h0)
      else $error("collision did not release lines");
   a_stop_done: assert property (s_tail_expire |=> s_stop_finished)
      else $error("stop did not finish after tail period");
   a_coll_sticky: assert property (irq_stat_ff[IRQ_COLL] && !(wr && adr_i == ADR_IRQ_STAT && dat_i[IRQ_COLL])
      |=> irq_stat_ff[IRQ_COLL] && state_ff == SCD_IDLE)
      else $error("collision flag lost or stop restarted");
   a_mask_share: assert property (wr && adr_i == ADR_RELOAD && ctrl1_ff[3:0] == MODE_SLV_MASK |=> $stable(reload_ff))
      else $error("mask write reached reload register");
   a_alt_bits: assert property (wr && adr_i == ADR_CTRL2 && !master |=> adm_ff == $past(dat_i[5:1]))
      else $error("slave mode mask bits not stored");
endmodule : scd_stop_collide
`default_nettype wire

// ===== pkg/scd_pkg.sv
`default_nettype none
package scd_pkg;
   // Register byte offsets on the bus.
   localparam logic [7:0] ADR_BUF      = 8'h00;
   localparam logic [7:0] ADR_RELOAD   = 8'h04;
   localparam logic [7:0] ADR_CTRL1    = 8'h08;
   localparam logic [7:0] ADR_CTRL2    = 8'h0c;
   localparam logic [7:0] ADR_STAT     = 8'h10;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
   // Field positions.
   localparam int C1_WCOL   = 7;
   localparam int C1_EN     = 5;
   localparam int C2_GCEN   = 7;
   localparam int C2_PEN    = 2;
   localparam int C2_SEN    = 0;
   localparam int ST_STOP   = 4;
   localparam int IRQ_XFER  = 0;
   localparam int IRQ_COLL  = 1;
   localparam int IRQ_W     = 2;
   localparam int RELOAD_W  = 7;
   // Cycles that the block's own data release needs to pass the synchroniser.
   localparam logic [1:0] SETTLE_CYC = 2'h2;
   // Port mode codes held in the low nibble of control one.
   localparam logic [3:0] MODE_MASTER   = 4'h8;
   localparam logic [3:0] MODE_SLV_MASK = 4'h9;
   // Reset values.
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] RST_MASK  = 8'hff;
   localparam logic [1:0] RST_IRQ   = 2'h0;
   // Stop sequence states.
   typedef enum logic [2:0] {
      SCD_IDLE, SCD_SDA_LOW, SCD_SCL_WAIT, SCD_HOLD, SCD_SDA_REL, SCD_TAIL
   } scd_state_type;
endpackage : scd_pkg
`default_nettype wire

// ===== hw/scd_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module scd_sync2 #(
   parameter int W = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   // A synchroniser without any bits cannot be built.
   if (W < 1) begin : g_bad_width
      $error("scd_sync2 needs W of at least 1");
   end

   // The first stage feeds only the second stage.
   always_comb begin
      nxt_meta = d_i;
      nxt_sync = meta_ff;
   end

   // Idle bus lines are high, so both stages reset to ones.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign q_o = sync_ff;
endmodule : scd_sync2
`default_nettype wire

// ===== dv/scd_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// Other parties on the wired-and bus; a released line floats high on its pull-up.
module scd_bus_model (
   input  wire logic scl_oe_n_i,
   input  wire logic sda_oe_n_i,
   input  wire logic pull_scl_i,
   input  wire logic pull_sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // A line is low while any party pulls it, otherwise high.
   assign scl_o = ~(~scl_oe_n_i | pull_scl_i);
   assign sda_o = ~(~sda_oe_n_i | pull_sda_i);
endmodule : scd_bus_model
`default_nettype wire

// ===== dv/scd_stop_collide_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module scd_stop_collide_tb_top;
   import scd_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        pull_scl = 1'b0;
   logic        pull_sda = 1'b0;
   logic [31:0] rdat;
   logic        ack, scl, sda, scl_oe_n, sda_oe_n, irq, scl_lvl, sda_lvl;
   int          bad_count = 0;
   int          compares = 0;
   int          cycles = 0;
   int          m_irq = 0;
   int          m_mask = 0;
   int          m_reload = 0;
   bit          m_slave = 0;

   // System clock, 10 ns period.
   always #5 clk_i = ~clk_i;

   scd_stop_collide DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
      .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack), .scl_i(scl), .sda_i(sda),
      .scl_o(scl_lvl), .scl_oe_n_o(scl_oe_n), .sda_o(sda_lvl), .sda_oe_n_o(sda_oe_n), .irq_o(irq));

   scd_bus_model bus (.scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n), .pull_scl_i(pull_scl),
      .pull_sda_i(pull_sda), .scl_o(scl), .sda_o(sda));

   // A hung run is cut short and counted as a mismatch.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   // One classic Wishbone cycle; the request stands until ack is sampled high.
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
      adr <= a;
      we <= w;
      wdat <= {24'h0, d};
      sel <= 4'hf;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // Write, keeping the reference model of mask, status and reload in step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
      if (a == ADR_IRQ_MASK) m_mask = d & 3;
      if (a == ADR_IRQ_STAT) m_irq &= ~int'(d);
      if (a == ADR_CTRL1) m_slave = (d[3:0] == MODE_SLV_MASK);
      if (a == ADR_RELOAD && !m_slave) m_reload = d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(a, 1'b0, 8'h00, q);
   endtask : rd

   task automatic irq_chk();
      chk("irq_line", irq, (m_irq & m_mask) != 0);
   endtask : irq_chk

   task automatic wait_lvl(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 300) chk("wait", 1'b0, 1'b1);
   endtask : wait_lvl

   // Collision-free stop with reload n, then the mask and clear paths.
   task automatic stop_ok(input int n);
      int t;
      logic [31:0] q;
      wr(ADR_RELOAD, n[7:0]);
      wr(ADR_CTRL2, 8'h04);
      wait_lvl(sda_oe_n, 1'b0, t);
      wait_lvl(scl_oe_n, 1'b1, t);
      chk("sda_held", sda_oe_n, 1'b0);
      wait_lvl(sda_oe_n, 1'b1, t);
      chk("hold_len", t >= n + 1 && t <= n + 5, 1'b1);
      wait_lvl(irq, 1'b1, t);
      m_irq |= 1;
      // Release window and tail period both run a full count, plus synchroniser lag.
      chk("tail_len", t >= 2 * n + 2 && t <= 2 * n + 6, 1'b1);
      rd(ADR_STAT, q);
      chk("stop_bit", q[ST_STOP], 1'b1);
      rd(ADR_CTRL2, q);
      chk("pen_clear", q[C2_PEN], 1'b0);
      wr(ADR_IRQ_MASK, 8'h00);
      irq_chk();
      wr(ADR_IRQ_MASK, 8'h03);
      irq_chk();
      wr(ADR_IRQ_STAT, 8'h01);
      irq_chk();
      $display("test stop reload %0d done", n);
   endtask : stop_ok

   // Kind 0: data held low at expiry; kind 1: clock pulled low in the hold.
   task automatic coll(input int kind);
      int t;
      logic [31:0] q;
      pull_sda <= (kind == 0);
      wr(ADR_RELOAD, 8'h0a);
      wr(ADR_CTRL2, 8'h04);
      wait_lvl(scl_oe_n, 1'b1, t);
      if (kind == 1) begin
         repeat (5) @(posedge clk_i);
         pull_scl <= 1'b1;
      end
      wait_lvl(irq, 1'b1, t);
      m_irq |= 2;
      chk("coll_time", t < 40, 1'b1);
      chk("lines_free", {scl_oe_n, sda_oe_n}, 2'b11);
      rd(ADR_CTRL2, q);
      chk("seq_bits", q[5:0], 6'h00);
      pull_scl <= 1'b0;
      pull_sda <= 1'b0;
      wr(ADR_CTRL2, 8'h04);
      repeat (10) begin
         @(posedge clk_i);
         chk("no_restart", sda_oe_n, 1'b1);
      end
      rd(ADR_IRQ_STAT, q);
      chk("coll_flag", q, 32'h2);
      wr(ADR_IRQ_STAT, 8'h02);
      irq_chk();
      $display("test collision %0d done", kind);
   endtask : coll

   // Main sequence.
   initial begin
      int t;
      logic [31:0] q;
      void'($urandom(32'hd36def0e));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_IRQ_STAT, q);
      chk("irq_rst", q, {30'h0, RST_IRQ});
      rd(ADR_CTRL1, q);
      chk("ctrl1_rst", q, {24'h0, RST_BYTE});
      wr(8'h1c, 8'h55);
      rd(8'h1c, q);
      chk("unmapped", q, 32'h0);
      chk("oe_rst", {scl_oe_n, sda_oe_n, irq}, 3'b110);
      chk("pin_low", {scl_lvl, sda_lvl}, 2'b00);
      $display("test reset values done");
      wr(ADR_CTRL1, 8'h20 | {4'h0, MODE_MASTER});
      wr(ADR_IRQ_MASK, 8'h03);
      for (int i = 0; i < 4; i++) stop_ok(i == 0 ? 0 : i == 1 ? 127 : $urandom_range(30, 1));
      coll(0);
      coll(1);
      // Another party holds the clock low from before the stop until five cycles after the buffer write: no collision.
      pull_scl <= 1'b1;
      wr(ADR_RELOAD, 8'h04);
      wr(ADR_CTRL2, 8'h04);
      wait_lvl(scl_oe_n, 1'b1, t);
      wr(ADR_BUF, 8'ha5);
      repeat (5) @(posedge clk_i);
      chk("stretch_hold", sda_oe_n, 1'b0);
      pull_scl <= 1'b0;
      wait_lvl(sda_oe_n, 1'b1, t);
      chk("stretch_len", t >= 5 && t <= 10, 1'b1);
      wait_lvl(irq, 1'b1, t);
      rd(ADR_IRQ_STAT, q);
      chk("stretch_flag", q, 32'h1);
      wr(ADR_IRQ_STAT, 8'h01);
      rd(ADR_BUF, q);
      chk("buf_kept", q, {24'h0, RST_BYTE});
      rd(ADR_CTRL1, q);
      chk("write_coll", q[C1_WCOL], 1'b1);
      $display("test stretch done");
      // Slave masking mode: mask register and alternate control bits.
      wr(ADR_CTRL1, 8'h20 | {4'h0, MODE_SLV_MASK});
      rd(ADR_RELOAD, q);
      chk("mask_rst", q, {24'h0, RST_MASK});
      wr(ADR_RELOAD, 8'h5a);
      rd(ADR_RELOAD, q);
      chk("mask_rw", q, 32'h5a);
      wr(ADR_CTRL2, 8'h3e);
      repeat (10) begin
         @(posedge clk_i);
         chk("slave_idle", sda_oe_n, 1'b1);
      end
      rd(ADR_CTRL2, q);
      chk("addr_mask", q[5:1], 5'h1f);
      wr(ADR_CTRL2, 8'h00);
      wr(ADR_CTRL1, 8'h20 | {4'h0, MODE_MASTER});
      rd(ADR_RELOAD, q);
      chk("reload_kept", q, m_reload);
      $display("test slave mask done");
      end_of_test();
   end
endmodule : scd_stop_collide_tb_top
`default_nettype wire
